// *** rtl/ctl_mode_pkg.sv ***
// Constants, register map and carrier types for the controller mode block
package ctl_mode_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_EXT = 8'h04;
    localparam logic [7:0] ADDR_TRIM = 8'h08;
    localparam logic [7:0] ADDR_RANGE = 8'h0c;
    localparam logic [7:0] ADDR_DI0 = 8'h10;
    localparam logic [7:0] ADDR_DI1 = 8'h14;
    localparam logic [7:0] ADDR_DI2 = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1c;
    localparam logic [7:0] ADDR_STAT = 8'h20;
    localparam logic [7:0] ADDR_PV = 8'h24;
    localparam logic [7:0] ADDR_MV = 8'h28;
    // Configuration field positions
    localparam int CFG_LOCK_LSB = 0;
    localparam int CFG_BRD_LSB = 4;
    localparam int CFG_TC_BIT = 6;
    localparam int CFG_RACK_BIT = 8;
    localparam int CFG_REM_BIT = 9;
    localparam int CFG_ATP_BIT = 10;
    localparam int CFG_TPL_LSB = 16;
    localparam int CMD_APPLY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 3;
    // Reset values
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [15:0] RANGE_LO_RESET = 16'h0000;
    localparam logic [15:0] RANGE_HI_RESET = 16'h0190;
    // Burnout outputs in 0.1 percent units
    localparam logic signed [15:0] MV_BURN_LOW = 16'hff06;
    localparam logic signed [15:0] MV_BURN_UP = 16'h04e2;
    localparam int OVER_DIV = 20;
    // Key lock levels
    localparam logic [2:0] LOCK_NONE = 3'h0;
    localparam logic [2:0] LOCK_MAX = 3'h5;
    // Templates and input function codes
    localparam logic [7:0] TPL_MATH_A = 8'h32;
    localparam logic [7:0] TPL_MATH_B = 8'h33;
    localparam logic [7:0] TPL_REMOTE = 8'h35;
    localparam logic [7:0] FC_NONE = 8'h00;
    localparam logic [7:0] FC_STANDBY = 8'h01;
    localparam logic [7:0] FC_AT = 8'h1e;
    localparam logic [7:0] FC_LATCH = 8'h28;
    localparam logic [7:0] FC_TIMER0 = 8'h32;
    localparam logic [7:0] FC_REMOTE = 8'h3c;
    localparam logic [7:0] FC_MANUAL = 8'h46;
    localparam logic [7:0] FC_TRACK = 8'h50;
    localparam logic [7:0] FC_EXTOUT = 8'h67;
    localparam logic [7:0] FC_HISEL = 8'h8c;
    localparam int DI_BASE = 4;
    localparam int DI_NUM = 9;
    localparam int ALARM_NUM = 8;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int UNDER_SHOW_MS = 200;
    localparam int UNDER_SHOW_CYC = UNDER_SHOW_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        BRD_HOLD = 2'b00,
        BRD_LOW = 2'b01,
        BRD_UP = 2'b10,
        BRD_EXT = 2'b11
    } burnout_direction_e;

    typedef struct packed {
        logic valid;
        logic is_setpoint;
    } write_req_s;

    typedef struct packed {
        logic standby_request;
        logic at_start;
        logic at_stop;
        logic at_low_pv;
        logic latch_release;
        logic [7:0] alarm_timer_on;
        logic remote_select;
        logic manual_command;
        logic setpoint_tracking;
        logic external_output_select;
        logic hi_selector;
    } di_func_s;
endpackage : ctl_mode_pkg

// *** rtl/ctl_mode.sv ***
// Key lock, burnout output, input trim and digital input function decoding
//
// What this block does
// - Level zero lets keys and link write
// - Reads and display never blocked by lock
// - Lock never touches control or alarms
// - Levels one to five gate key/link writes
// - Hold direction freezes output before burnout
// - Low -25%, up 125%, external uses value
// - Sensor break, over range, no junction: overrange
// - B line break shows underrange briefly
// - Math template: any input burnout burns unit
// - Trims add on top; zero trims no effect
// - Equal zero and span trims give offset
// - Per-input function code, zero none, on active
// - Five extra inputs only on nine-input variant
// - Code 1 level gives standby, else run
// - Code 30 rise starts, fall stops tuning
// - Code 40 on releases all alarm latches
// - Codes 50-57 gate alarm 1-8 timers
// - Code 60 remote select, gated by setup
// - Code 70 manual mode, template 50/53 only
// - Code 140 picks high or low selector
// - Code 80 tracks setpoint, 103 external output
`timescale 1ns/1ps
module ctl_mode #(
    parameter int UNDER_CYC = ctl_mode_pkg::UNDER_SHOW_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input ctl_mode_pkg::write_req_s key_req,
    output logic key_wr_grant,
    input ctl_mode_pkg::write_req_s link_req,
    output logic link_wr_grant,
    input wire logic control_tick,
    input wire logic signed [15:0] pv_raw,
    input wire logic signed [15:0] computed_mv,
    input wire logic sensor_break_pin,
    input wire logic rtd_b_break_pin,
    input wire logic cjc_present_pin,
    input wire logic pv2_burnout_pin,
    input wire logic ai1_burnout_pin,
    input wire logic nine_input_pin,
    input wire logic [8:0] di_pin,
    output logic signed [15:0] pv_out,
    output logic signed [15:0] mv_out,
    output logic overrange_indication,
    output logic underrange_indication,
    output logic burnout,
    output logic [7:0] template_active,
    output ctl_mode_pkg::di_func_s di_func
);
    import ctl_mode_pkg::*;

    function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sd32767) begin
            return 16'sh7fff;
        end else if (v < -48'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    // Configuration registers
    logic [31:0] cfg;
    logic signed [15:0] external_output_value;
    logic signed [15:0] input_zero_trim;
    logic signed [15:0] input_span_trim;
    logic signed [15:0] range_lo;
    logic signed [15:0] range_hi;
    logic [7:0] input_function_code [DI_NUM];
    logic write_refused;
    logic [2:0] keylock_level;
    burnout_direction_e burnout_direction;
    logic is_thermocouple;
    logic remote_ack_enable;
    logic remote_mode;
    logic nine_input;

    assign keylock_level = cfg[CFG_LOCK_LSB +: 3];
    assign burnout_direction = burnout_direction_e'(cfg[CFG_BRD_LSB +: 2]);
    assign is_thermocouple = cfg[CFG_TC_BIT];
    assign remote_ack_enable = cfg[CFG_RACK_BIT];
    assign remote_mode = cfg[CFG_REM_BIT];

    // APB decode, zero wait states
    logic wr_en;
    logic rd_valid;
    logic addr_ok;
    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;
    always_comb begin
        unique case (paddr)
            ADDR_CFG, ADDR_EXT, ADDR_TRIM, ADDR_RANGE, ADDR_DI0, ADDR_DI1,
            ADDR_DI2, ADDR_CMD, ADDR_STAT, ADDR_PV, ADDR_MV: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;
    assign rd_valid = psel & ~pwrite & addr_ok;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= CFG_RESET;
            external_output_value <= '0;
            input_zero_trim <= '0;
            input_span_trim <= '0;
            range_lo <= RANGE_LO_RESET;
            range_hi <= RANGE_HI_RESET;
            for (int i = 0; i < DI_NUM; i++) begin
                input_function_code[i] <= FC_NONE;
            end
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_CFG: cfg <= pwdata;
                ADDR_EXT: external_output_value <= pwdata[15:0];
                ADDR_TRIM: begin
                    input_zero_trim <= pwdata[15:0];
                    input_span_trim <= pwdata[31:16];
                end
                ADDR_RANGE: begin
                    range_lo <= pwdata[15:0];
                    range_hi <= pwdata[31:16];
                end
                ADDR_DI0: for (int i = 0; i < 4; i++) begin
                    input_function_code[i] <= pwdata[8*i +: 8];
                end
                ADDR_DI1: for (int i = 0; i < 4; i++) begin
                    input_function_code[i+4] <= pwdata[8*i +: 8];
                end
                ADDR_DI2: input_function_code[8] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // New template becomes active only on a restart command
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            template_active <= CFG_RESET[CFG_TPL_LSB +: 8];
        end else if (wr_en && paddr == ADDR_CMD && pwdata[CMD_APPLY_BIT]) begin
            template_active <= cfg[CFG_TPL_LSB +: 8];
        end
    end

    // Reads are never gated by the lock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= '0;
        end else if (rd_valid && !penable) begin
            prdata <= '0;
            unique case (paddr)
                ADDR_CFG: prdata <= cfg;
                ADDR_EXT: prdata[15:0] <= external_output_value;
                ADDR_TRIM: prdata <= {input_span_trim, input_zero_trim};
                ADDR_RANGE: prdata <= {range_hi, range_lo};
                ADDR_DI0: prdata <= {input_function_code[3],
                    input_function_code[2], input_function_code[1],
                    input_function_code[0]};
                ADDR_DI1: prdata <= {input_function_code[7],
                    input_function_code[6], input_function_code[5],
                    input_function_code[4]};
                ADDR_DI2: prdata[7:0] <= input_function_code[8];
                ADDR_STAT: prdata <= {15'h0000, nine_input, template_active,
                    4'h0, write_refused, underrange_indication,
                    overrange_indication, burnout};
                ADDR_PV: prdata[15:0] <= pv_out;
                ADDR_MV: prdata[15:0] <= mv_out;
                default: ;
            endcase
        end
    end

    // Key lock write gating
    logic key_param_ok;
    logic key_sp_ok;
    logic link_ok;
    always_comb begin
        key_param_ok = 1'b0;
        key_sp_ok = 1'b0;
        link_ok = 1'b0;
        unique case (keylock_level)
            LOCK_NONE: begin
                key_param_ok = 1'b1;
                key_sp_ok = 1'b1;
                link_ok = 1'b1;
            end
            3'h1: link_ok = 1'b1;
            3'h2: begin
                key_sp_ok = 1'b1;
                link_ok = 1'b1;
            end
            3'h3: begin
                key_param_ok = 1'b1;
                key_sp_ok = 1'b1;
            end
            3'h4: ;
            LOCK_MAX: key_sp_ok = 1'b1;
            default: ;
        endcase
    end
    assign key_wr_grant = key_req.valid &
        (key_req.is_setpoint ? key_sp_ok : key_param_ok);
    assign link_wr_grant = link_req.valid & link_ok;

    // Refused write flag, set wins over a write-one clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            write_refused <= 1'b0;
        end else if ((key_req.valid && !key_wr_grant) ||
                (link_req.valid && !link_wr_grant)) begin
            write_refused <= 1'b1;
        end else if (wr_en && paddr == ADDR_STAT &&
                pwdata[STAT_REFUSED_BIT]) begin
            write_refused <= 1'b0;
        end
    end

    // Pin synchronisers
    logic [14:0] pin_meta;
    logic [14:0] pin_sync;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {nine_input_pin, ai1_burnout_pin, pv2_burnout_pin,
                cjc_present_pin, rtd_b_break_pin, sensor_break_pin, di_pin};
            pin_sync <= pin_meta;
        end
    end
    logic [8:0] di_level;
    logic sensor_break;
    logic rtd_b_break;
    logic cjc_present;
    logic pv2_burnout;
    logic ai1_burnout;
    assign sensor_break = pin_sync[9];
    assign rtd_b_break = pin_sync[10];
    assign cjc_present = pin_sync[11];
    assign pv2_burnout = pin_sync[12];
    assign ai1_burnout = pin_sync[13];
    assign nine_input = pin_sync[14];
    assign di_level = pin_sync[8:0] &
        {{(DI_NUM-DI_BASE){nine_input}}, {DI_BASE{1'b1}}};

    // Zero and span trim over the factory-calibrated reading
    logic signed [16:0] fs;
    logic signed [47:0] span_term;
    logic signed [47:0] trimmed;
    assign fs = 17'(range_hi) - 17'(range_lo);
    always_comb begin
        span_term = 48'(input_span_trim - input_zero_trim) *
            48'(48'(pv_raw) - 48'(range_lo));
        if (fs > 17'sd0) begin
            span_term = span_term / 48'(fs);
        end else begin
            span_term = '0;
        end
        trimmed = 48'(pv_raw) + 48'(input_zero_trim) + span_term;
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pv_out <= '0;
        end else begin
            pv_out <= sat16(trimmed);
        end
    end

    // Over range and underrange window
    logic signed [47:0] over_limit;
    logic over_limit_hit;
    logic rtd_b_prev;
    logic [31:0] under_cnt;
    logic b_break_burn;
    assign over_limit = 48'(range_hi) + 48'(fs) / OVER_DIV;
    assign over_limit_hit = 48'(pv_out) > over_limit;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            overrange_indication <= 1'b0;
        end else begin
            overrange_indication <= sensor_break | over_limit_hit |
                (is_thermocouple & ~cjc_present);
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rtd_b_prev <= 1'b0;
            under_cnt <= '0;
            underrange_indication <= 1'b0;
        end else begin
            rtd_b_prev <= rtd_b_break;
            if (rtd_b_break && !rtd_b_prev) begin
                under_cnt <= 32'(UNDER_CYC);
                underrange_indication <= 1'b1;
            end else if (under_cnt > 32'd1 && rtd_b_break) begin
                under_cnt <= under_cnt - 32'd1;
            end else begin
                under_cnt <= '0;
                underrange_indication <= 1'b0;
            end
        end
    end
    assign b_break_burn = rtd_b_break & rtd_b_prev & ~underrange_indication;

    // Burnout state, math inputs count under math templates
    logic math_active;
    logic next_burnout;
    assign math_active = template_active == TPL_MATH_A ||
        template_active == TPL_MATH_B;
    assign next_burnout = overrange_indication | b_break_burn |
        (math_active & (pv2_burnout | ai1_burnout));
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            burnout <= 1'b0;
        end else begin
            burnout <= next_burnout;
        end
    end

    // Manipulated output selection; lock has no influence here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mv_out <= '0;
        end else if (burnout) begin
            unique case (burnout_direction)
                BRD_HOLD: mv_out <= mv_out;
                BRD_LOW: mv_out <= MV_BURN_LOW;
                BRD_UP: mv_out <= MV_BURN_UP;
                BRD_EXT: mv_out <= external_output_value;
            endcase
        end else if (di_func.external_output_select) begin
            mv_out <= external_output_value;
        end else begin
            mv_out <= computed_mv;
        end
    end

    // Digital input function decode
    function automatic logic any_code(input logic [8:0] lvl,
            input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_NUM; i++) begin
            if (input_function_code[i] == code && code != FC_NONE) begin
                hit = hit | lvl[i];
            end
        end
        return hit;
    endfunction : any_code

    logic [8:0] di_prev;
    logic at_now;
    logic at_before;
    logic latch_now;
    logic latch_before;
    logic tpl_manual_ok;
    assign at_now = any_code(di_level, FC_AT);
    assign at_before = any_code(di_prev, FC_AT);
    assign latch_now = any_code(di_level, FC_LATCH);
    assign latch_before = any_code(di_prev, FC_LATCH);
    assign tpl_manual_ok = template_active == TPL_MATH_A ||
        template_active == TPL_REMOTE;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            di_prev <= '0;
        end else if (control_tick) begin
            di_prev <= di_level;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            di_func <= '0;
        end else begin
            di_func.standby_request <= any_code(di_level, FC_STANDBY);
            di_func.at_start <= control_tick & at_now & ~at_before;
            di_func.at_stop <= control_tick & ~at_now & at_before;
            di_func.at_low_pv <= cfg[CFG_ATP_BIT];
            di_func.latch_release <= control_tick & latch_now &
                ~latch_before;
            for (int a = 0; a < ALARM_NUM; a++) begin
                di_func.alarm_timer_on[a] <= any_code(di_level,
                    FC_TIMER0 + 8'(a));
            end
            di_func.remote_select <= any_code(di_level, FC_REMOTE) &
                tpl_manual_ok & remote_ack_enable & remote_mode;
            di_func.manual_command <= any_code(di_level, FC_MANUAL) &
                tpl_manual_ok;
            di_func.setpoint_tracking <= any_code(di_level, FC_TRACK);
            di_func.external_output_select <=
                any_code(di_level, FC_EXTOUT);
            di_func.hi_selector <= any_code(di_level, FC_HISEL);
        end
    end

    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    lock_zero_a: assert property (
        keylock_level == LOCK_NONE && key_req.valid && link_req.valid
        |-> key_wr_grant && link_wr_grant)
        else $error("writes refused at lock level zero");
    lock_link_a: assert property (
        keylock_level >= 3'h3 && link_req.valid |-> !link_wr_grant)
        else $error("link write granted while link locked");
    lock_key_sp_a: assert property (
        keylock_level == LOCK_MAX && key_req.valid && key_req.is_setpoint
        |-> key_wr_grant)
        else $error("key setpoint refused at top lock level");
    refused_flag_a: assert property (
        link_req.valid && !link_wr_grant |=> write_refused)
        else $error("refused write not flagged");
    hold_mv_a: assert property (
        burnout && $past(burnout) && burnout_direction == BRD_HOLD
        && $stable(burnout_direction) |=> $stable(mv_out))
        else $error("output moved during hold burnout");
    burn_up_a: assert property (
        burnout && burnout_direction == BRD_UP |=> mv_out == MV_BURN_UP)
        else $error("up burnout output wrong");
    under_brief_a: assert property (
        $rose(underrange_indication) |=> underrange_indication || !rtd_b_break
        || UNDER_CYC <= 1)
        else $error("underrange dropped early");
    tpl_apply_a: assert property (
        !(wr_en && paddr == ADDR_CMD) |=> $stable(template_active))
        else $error("template changed without restart");
    math_burn_a: assert property (
        math_active && pv2_burnout |=> burnout)
        else $error("math input burnout ignored");
    offset_a: assert property (
        input_zero_trim == input_span_trim && $stable(pv_raw)
        && $stable(input_zero_trim) |=> pv_out ==
        sat16(48'($past(pv_raw)) + 48'($past(input_zero_trim))))
        else $error("equal trims not a pure offset");

    burn_ext_c: cover property (burnout && burnout_direction == BRD_EXT);
    at_start_c: cover property (di_func.at_start);
    under_c: cover property ($fell(underrange_indication) && rtd_b_break);
    refused_c: cover property (key_req.valid && !key_wr_grant);
endmodule : ctl_mode

// *** verification/field_side.sv ***
// Field contacts, front keys and link host facing the mode block
`timescale 1ns/1ps
module field_side (
    input wire logic mclk,
    input wire logic [1:0] key_cmd,
    input wire logic [1:0] link_cmd,
    input wire logic [8:0] di_cmd,
    output ctl_mode_pkg::write_req_s key_req,
    output ctl_mode_pkg::write_req_s link_req,
    output logic [8:0] di_pin
);
    import ctl_mode_pkg::*;
    // Contacts and requests move just after the clock edge
    always @(posedge mclk) begin
        key_req <= key_cmd;
        link_req <= link_cmd;
        di_pin <= di_cmd;
    end
endmodule : field_side

// *** verification/tb_top.sv ***
// Self-checking bench for the controller mode block
`timescale 1ns/1ps
module tb_top;
    import ctl_mode_pkg::*;
    localparam logic [17:0] LOCK_TBL = 18'h0_7b49;
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, cd, tpl;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] key_cmd, link_cmd;
    logic [8:0] di_cmd, di_pin;
    write_req_s key_req, link_req;
    logic key_wr_grant, link_wr_grant, control_tick;
    logic sensor_break_pin, rtd_b_break_pin, burnout, pv2_pin;
    logic overrange_indication, underrange_indication;
    logic signed [15:0] pv_raw, computed_mv, pv_out, mv_out;
    logic [15:0] lf = 16'hf6f0;
    logic [15:0] z, rv, ext;
    di_func_s di_func;
    logic [7:0] codes[7] = '{FC_NONE, FC_STANDBY, FC_TRACK, FC_EXTOUT,
        FC_HISEL, FC_MANUAL, FC_REMOTE};
    int bad_count = 0;
    int n_compared = 0;
    int pulses = 0;
    int h;

    field_side partner (.mclk, .key_cmd, .link_cmd, .di_cmd, .key_req,
        .link_req, .di_pin);
    ctl_mode #(.UNDER_CYC(8)) dut (.mclk, .arst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_req,
        .key_wr_grant, .link_req, .link_wr_grant, .control_tick, .pv_raw,
        .computed_mv, .sensor_break_pin, .rtd_b_break_pin,
        .cjc_present_pin(1'b1), .pv2_burnout_pin(pv2_pin),
        .ai1_burnout_pin(1'b0), .nine_input_pin(1'b1), .di_pin, .pv_out,
        .mv_out, .overrange_indication, .underrange_indication, .burnout,
        .template_active(tpl), .di_func);

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    function automatic logic [15:0] mv_exp(input int d,
                                           input logic [15:0] hv, xv);
        case (d)
            0: return hv;
            1: return MV_BURN_LOW;
            2: return MV_BURN_UP;
            default: return xv;
        endcase
    endfunction : mv_exp
    function automatic logic [17:0] di_exp(input logic [7:0] c);
        if (c >= FC_TIMER0 && c < FC_TIMER0 + 8) begin
            return 18'h0_0020 << (c - FC_TIMER0);
        end
        case (c)
            FC_STANDBY: return 18'h2_0000;
            FC_TRACK: return 18'h0_0004;
            FC_EXTOUT: return 18'h0_0002;
            FC_HISEL: return 18'h0_0001;
            default: return 18'h0_0000;
        endcase
    endfunction : di_exp

    task automatic chk(input string nm, input logic [31:0] ex, got);
        n_compared++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    always @(posedge mclk) begin
        control_tick <= !control_tick;
        pulses <= pulses + di_func.at_start + di_func.at_stop
            + di_func.latch_release;
    end
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        results();
    end
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {key_cmd, link_cmd, di_cmd, control_tick} = '0;
        {sensor_break_pin, rtd_b_break_pin, pv_raw, computed_mv} = '0;
        pv2_pin = 1'b0;
        wt(6);
        arst_n <= 1'b1;
        wt(1);
        apb(0, ADDR_RANGE, 0);
        chk("range", {RANGE_HI_RESET, RANGE_LO_RESET}, q);
        apb(0, 8'h40, 0);
        chk("slverr", 1, err);
        for (int l = 0; l < 6; l++) begin
            apb(1, ADDR_CFG, l);
            for (int s = 0; s < 2; s++) begin
                key_cmd <= {1'b1, s[0]};
                link_cmd <= {1'b1, s[0]};
                wt(3);
                chk("key grant", LOCK_TBL[s*6+l], key_wr_grant);
                chk("link grant", LOCK_TBL[12+l], link_wr_grant);
            end
            key_cmd <= 0;
            link_cmd <= 0;
            apb(0, ADDR_CFG, 0);
            chk("cfg read", l, q);
        end
        apb(0, ADDR_STAT, 0);
        chk("refused", 1, q[STAT_REFUSED_BIT]);
        $display("lock test done");
        lf = nxt(lf);
        ext = lf;
        apb(1, ADDR_EXT, ext);
        for (int d = 0; d < 4; d++) begin
            apb(1, ADDR_CFG, (d << CFG_BRD_LSB) | 4);
            lf = nxt(lf);
            computed_mv <= lf;
            wt(4);
            chk("mv run", lf, mv_out[15:0]);
            sensor_break_pin <= 1'b1;
            wt(6);
            chk("over", 1, overrange_indication);
            computed_mv <= 16'h0123;
            wt(4);
            chk("mv burn", mv_exp(d, lf, ext), mv_out[15:0]);
            sensor_break_pin <= 1'b0;
            wt(6);
        end
        rtd_b_break_pin <= 1'b1;
        wt(5);
        chk("under", 1, underrange_indication);
        chk("early burn", 0, burnout);
        wt(15);
        chk("late burn", 1, burnout);
        rtd_b_break_pin <= 1'b0;
        wt(6);
        $display("burnout test done");
        apb(1, ADDR_CFG, 0);
        for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            z = i ? {{8{lf[7]}}, lf[7:0]} : 16'h0000;
            rv = {8'h00, lf[15:8]};
            apb(1, ADDR_TRIM, {z, z});
            pv_raw <= rv;
            wt(4);
            rv = rv + z;
            chk("pv", rv, pv_out[15:0]);
        end
        apb(1, ADDR_TRIM, 0);
        for (int i = 0; i < 2; i++) begin
            pv_raw <= 420 + i;
            wt(6);
            chk("over edge", i, overrange_indication);
        end
        pv_raw <= 0;
        $display("trim test done");
        for (int i = 0; i < 15; i++) begin
            cd = i < 8 ? FC_TIMER0 + 8'(i) : codes[i-8];
            apb(1, ADDR_DI0, cd);
            di_cmd <= 9'h001;
            wt(5);
            chk("di on", di_exp(cd), di_func);
            di_cmd <= 9'h000;
            wt(5);
            chk("di off", 0, di_func);
        end
        h = pulses;
        apb(1, ADDR_DI0, FC_AT);
        di_cmd <= 9'h001;
        wt(8);
        di_cmd <= 9'h000;
        wt(8);
        chk("tuning edges", h + 2, pulses);
        apb(1, ADDR_DI0, FC_LATCH);
        di_cmd <= 9'h001;
        wt(8);
        di_cmd <= 9'h000;
        wt(8);
        chk("release", h + 3, pulses);
        $display("input test done");
        apb(1, ADDR_CFG, 32'(TPL_MATH_A) << CFG_TPL_LSB);
        chk("tpl staged", 0, tpl);
        apb(1, ADDR_CMD, 1);
        chk("tpl active", TPL_MATH_A, tpl);
        pv2_pin <= 1'b1;
        wt(6);
        chk("math burn", 1, burnout);
        pv2_pin <= 1'b0;
        apb(1, ADDR_DI0, FC_MANUAL);
        di_cmd <= 9'h001;
        wt(5);
        chk("manual", 1, di_func.manual_command);
        di_cmd <= 9'h000;
        $display("template test done");
        results();
    end
endmodule : tb_top
